// >>> src/dip_pkg.sv
// constants, types and helpers for the dwell and interrupt sequencer
package dip_pkg;

	localparam int DATA_W       = 32;
	localparam int OP_W         = 3;
	localparam int NUM_PROG_IN  = 3;
	localparam int NUM_PROG_OUT = 3;

	// step operation codes from the stored program
	localparam logic [OP_W-1:0] OP_DWELL_STEP      = 3'h1;
	localparam logic [OP_W-1:0] OP_WAIT_INPUT_STEP = 3'h2;
	localparam logic [OP_W-1:0] OP_INTERRUPT_POS   = 3'h3;
	localparam logic [OP_W-1:0] OP_OUTPUT_ON_STEP  = 3'h4;

	// dwell unit is one millisecond
	localparam int DWELL_UNIT_NS  = 1000000;
	localparam int CORE_PERIOD_NS = 8;
	localparam int CYC_PER_MS     = DWELL_UNIT_NS / CORE_PERIOD_NS;

	localparam logic [NUM_PROG_OUT-1:0] PROG_OUT_RST = 3'h0;
	localparam logic [DATA_W-1:0]       POS_RST      = 32'h0;

	typedef enum logic [4:0] {
		ST_IDLE       = 5'h01,
		ST_DWELL_ZERO = 5'h02,
		ST_DWELL_RUN  = 5'h04,
		ST_WAIT_IN    = 5'h08,
		ST_ITP_RUN    = 5'h10
	} dip_state_t;

	// program input n (1..3) level, zero for any other n
	function automatic logic dip_sel_input(
		input logic [NUM_PROG_IN-1:0] ins,
		input logic [1:0]             n
	);
		logic r;
		r = 1'b0;
		case (n)
			2'h1: r = ins[0];
			2'h2: r = ins[1];
			2'h3: r = ins[2];
			default: r = 1'b0;
		endcase
		return r;
	endfunction : dip_sel_input

	// one-hot mask of program output n (1..3)
	function automatic logic [NUM_PROG_OUT-1:0] dip_out_mask(
		input logic [1:0] n
	);
		logic [NUM_PROG_OUT-1:0] m;
		m = 3'h0;
		case (n)
			2'h1: m = 3'h1;
			2'h2: m = 3'h2;
			2'h3: m = 3'h4;
			default: m = 3'h0;
		endcase
		return m;
	endfunction : dip_out_mask

endpackage : dip_pkg

// >>> src/dip_timer_if.sv
// handshake between the sequencer and its dwell timer
`timescale 1ns/1ps
interface dip_timer_if;
	logic                      start;
	logic [dip_pkg::DATA_W-1:0] ms;
	logic                      done;

	modport master (output start, output ms, input done);
	modport timer  (input start, input ms, output done);
endinterface : dip_timer_if

// >>> src/dip_dwell_timer.sv
// millisecond dwell timer with its own divider
`timescale 1ns/1ps
module dip_dwell_timer #(
	parameter int CYC_PER_MS = dip_pkg::CYC_PER_MS
) (
	input  wire logic  i_core_clk,
	input  wire logic  i_rst_n,
	dip_timer_if.timer tif
);
	import dip_pkg::*;

	localparam int DIV_W = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_PER_MS - 1);

	logic              busy;
	logic [DIV_W-1:0]  div;
	logic [DATA_W-1:0] ms_left;
	logic              done;

	assign tif.done = done;

	// one-cycle tick every millisecond while busy
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div <= '0;
		end else if (tif.start || !busy || div == DIV_LAST) begin
			div <= '0;
		end else begin
			div <= div + 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy    <= 1'b0;
			ms_left <= '0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (tif.start) begin
				busy    <= 1'b1;
				ms_left <= tif.ms;
			end else if (busy && ms_left == '0) begin
				busy <= 1'b0;
				done <= 1'b1;
			end else if (busy && div == DIV_LAST) begin
				ms_left <= ms_left - 1'b1;
			end
		end
	end

	a_done_single: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		done |=> !done)
		else $error("dwell done longer than one cycle");

	a_done_cause: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		done |-> $past(busy) && $past(ms_left) == '0)
		else $error("dwell done without expired count");

endmodule : dip_dwell_timer

// >>> src/dip_sequencer.sv
// step sequencer for dwell, wait-for-input and interrupt positioning steps
`timescale 1ns/1ps
module dip_sequencer #(
	parameter int CYC_PER_MS = dip_pkg::CYC_PER_MS
) (
	input  wire logic                              i_core_clk,
	input  wire logic                              i_arst_n,
	input  wire logic                              i_step_valid,
	input  wire logic [dip_pkg::OP_W-1:0]          i_step_op,
	input  wire logic [dip_pkg::DATA_W-1:0]        i_step_arg,
	input  wire logic [dip_pkg::NUM_PROG_IN-1:0]   i_prog_in,
	input  wire logic [dip_pkg::DATA_W-1:0]        i_remaining,
	input  wire logic [dip_pkg::DATA_W-1:0]        i_travel_cmd,
	input  wire logic                              i_decel,
	input  wire logic [dip_pkg::DATA_W-1:0]        i_position,
	input  wire logic                              i_dir_neg,
	input  wire logic [dip_pkg::DATA_W-1:0]        i_brake_dist,
	output logic                                   o_step_ack,
	output logic                                   o_itp_go,
	output logic [dip_pkg::DATA_W-1:0]             o_itp_target,
	output logic                                   o_itp_short,
	output logic [dip_pkg::NUM_PROG_OUT-1:0]       o_prog_out
);
	import dip_pkg::*;

	logic                    rst_s1;
	logic                    rst_n;
	logic [NUM_PROG_IN-1:0]  in_s1;
	logic [NUM_PROG_IN-1:0]  in_s2;
	dip_state_t              state;
	logic [1:0]              in_sel;
	logic [DATA_W-1:0]       dwell_ms;
	logic [DATA_W-1:0]       cap_pos;
	logic                    tmr_start;
	logic                    take;
	logic                    itp_skip;
	logic                    in_on;

	dip_timer_if tif ();

	assign tif.start = tmr_start;
	assign tif.ms    = dwell_ms;

	dip_dwell_timer #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_timer (
		.i_core_clk (i_core_clk),
		.i_rst_n    (rst_n),
		.tif        (tif)
	);

	// reset release through two flops
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// program inputs are pins
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_s1 <= '0;
			in_s2 <= '0;
		end else begin
			in_s1 <= i_prog_in;
			in_s2 <= in_s1;
		end
	end

	// a new step is taken only in idle and never right after an ack
	assign take  = (state == ST_IDLE) && i_step_valid && !o_step_ack;
	assign in_on = dip_sel_input(in_s2, in_sel);

	// skip conditions for an interrupt step
	assign itp_skip = (i_step_arg < i_travel_cmd)
		|| (i_remaining <= i_step_arg)
		|| i_decel;

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state      <= ST_IDLE;
			o_step_ack <= 1'b0;
			o_itp_go   <= 1'b0;
			tmr_start  <= 1'b0;
			in_sel     <= 2'h0;
			dwell_ms   <= '0;
		end else begin
			o_step_ack <= 1'b0;
			o_itp_go   <= 1'b0;
			tmr_start  <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (take) begin
						case (i_step_op)
							OP_DWELL_STEP: begin
								dwell_ms <= i_step_arg;
								state    <= ST_DWELL_ZERO;
							end
							OP_WAIT_INPUT_STEP: begin
								in_sel <= i_step_arg[1:0];
								state  <= ST_WAIT_IN;
							end
							OP_INTERRUPT_POS: begin
								if (itp_skip) begin
									o_step_ack <= 1'b1;
								end else begin
									o_itp_go <= 1'b1;
									state    <= ST_ITP_RUN;
								end
							end
							default: begin
								o_step_ack <= 1'b1;
							end
						endcase
					end
				end
				ST_DWELL_ZERO: begin
					if (i_remaining == '0) begin
						tmr_start <= 1'b1;
						state     <= ST_DWELL_RUN;
					end
				end
				ST_DWELL_RUN: begin
					if (tif.done) begin
						o_step_ack <= 1'b1;
						state      <= ST_IDLE;
					end
				end
				ST_WAIT_IN: begin
					if (in_on) begin
						o_step_ack <= 1'b1;
						state      <= ST_IDLE;
					end
				end
				ST_ITP_RUN: begin
					if (!o_itp_go && i_remaining == '0) begin
						o_step_ack <= 1'b1;
						state      <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// position latched when the awaited input switches on
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_pos <= POS_RST;
		end else if (state == ST_WAIT_IN && in_on) begin
			cap_pos <= i_position;
		end
	end

	// end point is exactly the distance beyond the latched position
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_itp_target <= POS_RST;
			o_itp_short  <= 1'b0;
		end else if (take && i_step_op == OP_INTERRUPT_POS && !itp_skip) begin
			o_itp_target <= i_dir_neg ? cap_pos - i_step_arg
				: cap_pos + i_step_arg;
			// motion generator brakes harder than the set constant
			o_itp_short  <= i_step_arg < i_brake_dist;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_prog_out <= PROG_OUT_RST;
		end else if (take && i_step_op == OP_OUTPUT_ON_STEP) begin
			o_prog_out <= o_prog_out
				| dip_out_mask(i_step_arg[1:0]);
		end
	end

	a_dwell_zero_hold: assert property (
		@(posedge i_core_clk) disable iff (!rst_n)
		state == ST_DWELL_ZERO && i_remaining != '0
		|=> !tmr_start && !o_step_ack)
		else $error("dwell started before travel ended");

	a_dwell_ack: assert property (
		@(posedge i_core_clk) disable iff (!rst_n)
		state == ST_DWELL_RUN && tif.done
		|=> o_step_ack && state == ST_IDLE)
		else $error("dwell expiry did not advance");

	a_skip_small: assert property (
		@(posedge i_core_clk) disable iff (!rst_n)
		take && i_step_op == OP_INTERRUPT_POS && i_step_arg < i_travel_cmd
		|=> o_step_ack && !o_itp_go)
		else $error("small interrupt distance not skipped");

	a_skip_remain: assert property (
		@(posedge i_core_clk) disable iff (!rst_n)
		take && i_step_op == OP_INTERRUPT_POS && i_remaining <= i_step_arg
		|=> o_step_ack && !o_itp_go)
		else $error("interrupt step not skipped on short remaining");

	a_skip_decel: assert property (
		@(posedge i_core_clk) disable iff (!rst_n)
		take && i_step_op == OP_INTERRUPT_POS && i_decel
		|=> o_step_ack && state == ST_IDLE)
		else $error("interrupt step ran while decelerating");

	a_itp_target: assert property (
		@(posedge i_core_clk) disable iff (!rst_n)
		o_itp_go && !$past(i_dir_neg)
		|-> o_itp_target == $past(cap_pos) + $past(i_step_arg))
		else $error("interrupt target not latched position plus distance");

	a_itp_target_neg: assert property (
		@(posedge i_core_clk) disable iff (!rst_n)
		o_itp_go && $past(i_dir_neg)
		|-> o_itp_target == $past(cap_pos) - $past(i_step_arg))
		else $error("interrupt target not latched position minus distance");

	a_itp_short: assert property (
		@(posedge i_core_clk) disable iff (!rst_n)
		o_itp_go
		|-> o_itp_short == ($past(i_step_arg) < $past(i_brake_dist)))
		else $error("short braking flag wrong");

	a_wait_hold: assert property (
		@(posedge i_core_clk) disable iff (!rst_n)
		state == ST_WAIT_IN && !in_on
		|=> !o_step_ack && state == ST_WAIT_IN)
		else $error("wait step advanced without its input");

	a_ack_spacing: assert property (
		@(posedge i_core_clk) disable iff (!rst_n)
		o_step_ack |=> !o_step_ack)
		else $error("two steps acknowledged back to back");

endmodule : dip_sequencer

// >>> tb/dip_motion_model.sv
// motion generator model facing the step sequencer
`timescale 1ns/1ps
module dip_motion_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_go,
	input  wire logic [31:0] i_target,
	input  wire logic        i_dir_neg,
	input  wire logic        i_load,
	input  wire logic [31:0] i_load_val,
	output logic      [31:0] o_remaining,
	output logic      [31:0] o_position
);
	// one unit a cycle; a go with no load in the same cycle replaces the travel and ends on target
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_remaining <= 32'h0;
			o_position  <= 32'h0;
		end else if (i_load) begin
			o_remaining <= i_load_val;
		end else if (i_go) begin
			o_remaining <= i_dir_neg ? o_position - i_target
				: i_target - o_position;
		end else if (o_remaining != 32'h0) begin
			o_remaining <= o_remaining - 32'h1;
			o_position  <= i_dir_neg ? o_position - 32'h1
				: o_position + 32'h1;
		end
	end
endmodule : dip_motion_model

// >>> tb/dip_sequencer_tb.sv
// self-checking bench for the dwell and interrupt positioning sequencer
`timescale 1ns/1ps
`define CHK(nm, exp_v, got_v) begin \
	samples_checked++; \
	if ((exp_v) !== (got_v)) begin \
		fail_count++; \
		$display("MISMATCH %s exp %0h got %0h", nm, exp_v, got_v); \
	end \
end
module dip_sequencer_tb;
	import dip_pkg::*;
	localparam int CPM = 4;
	logic            clk, arst_n, valid, decel, load, go, ack, shrt, dir;
	logic [OP_W-1:0] op;
	logic [31:0]     arg, tcmd, brake, lval, rem, pos, seed, prev_rem;
	logic [31:0]     p_pin, d, v, tgt;
	logic [2:0]      pin, pout;
	int              fail_count, samples_checked, cyc, zero_at, gos, n, a, g;

	dip_sequencer #(.CYC_PER_MS(CPM)) dip_sequencer_i (.i_core_clk(clk),
		.i_arst_n(arst_n), .i_step_valid(valid), .i_step_op(op),
		.i_step_arg(arg), .i_prog_in(pin), .i_remaining(rem),
		.i_travel_cmd(tcmd), .i_decel(decel), .i_position(pos),
		.i_dir_neg(dir), .i_brake_dist(brake), .o_step_ack(ack),
		.o_itp_go(go), .o_itp_target(tgt), .o_itp_short(shrt),
		.o_prog_out(pout));
	dip_motion_model dip_motion_model_i (.i_core_clk(clk), .i_rst_n(arst_n),
		.i_go(go), .i_target(tgt), .i_dir_neg(dir), .i_load(load),
		.i_load_val(lval), .o_remaining(rem), .o_position(pos));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(negedge clk) begin
		cyc++;
		if (rem === 32'h0 && prev_rem !== 32'h0) zero_at = cyc;
		prev_rem = rem;
		if (go === 1'b1) gos++;
	end

	function automatic logic [31:0] rnd(input int m);
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed % m;
	endfunction : rnd

	task automatic print_verdict;
		$display("fails %0d checks %0d", fail_count, samples_checked);
		if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	// present one step and hold it until its ack, bounded
	task automatic step(input logic [OP_W-1:0] o, input logic [31:0] x);
		@(posedge clk);
		valid <= 1'b1;
		op    <= o;
		arg   <= x;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (ack !== 1'b1 && n < 3000);
		@(posedge clk);
		valid <= 1'b0;
		if (n >= 3000) begin
			fail_count++;
			print_verdict();
		end
	endtask : step

	task automatic load_rem(input logic [31:0] x);
		@(posedge clk);
		load <= 1'b1;
		lval <= x;
		@(posedge clk);
		load <= 1'b0;
	endtask : load_rem

	initial begin
		{arst_n, valid, decel, load, dir, op, arg, pin} = '0;
		{lval, tcmd, brake, prev_rem} = '0;
		{cyc, gos, zero_at, fail_count, samples_checked} = '0;
		seed = 32'h78CED84A;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK("rst_out", 5'h00, {ack, go, pout})
		// codes outside the step set are acknowledged with no action
		step(3'h0, rnd(4));
		`CHK("noop_lat", 2, n)
		step(3'(5 + rnd(3)), rnd(4));
		`CHK("noop_lat", 2, n)
		`CHK("noop_out", 3'h0, pout)
		for (int k = 1; k <= 3; k++) begin
			step(OP_OUTPUT_ON_STEP, k);
			`CHK("prog_out", 3'((1 << k) - 1), pout)
			`CHK("out_lat", 2, n)
		end
		// dwell counted from remaining reaching zero, zero time included
		repeat (5) begin
			a = rnd(3);
			load_rem(5 + rnd(20));
			step(OP_DWELL_STEP, a);
			d = cyc - zero_at;
			`CHK("dwell", 1'b1, d >= a*CPM + 1 && d <= a*CPM + a + 8)
		end
		// wait for input n, then the interrupt step; both directions
		for (int k = 0; k < 4; k++) begin
			a = 1 + rnd(3);
			dir <= k[0];
			load_rem(1000);
			fork
				step(OP_WAIT_INPUT_STEP, a);
				begin
					repeat (12) @(posedge clk);
					p_pin = pos;
					pin <= 3'(1 << (a - 1));
				end
			join
			`CHK("wait_lat", 1'b1, n >= 13 && n <= 17)
			v = 20 + rnd(30);
			tcmd  <= v - rnd(3);
			brake <= v + 5 - rnd(11);
			g = gos;
			step(OP_INTERRUPT_POS, v);
			d = dir ? p_pin - pos - v : pos - p_pin - v;
			`CHK("itp_go", g + 1, gos)
			`CHK("itp_stop", 1'b1, d >= 1 && d <= 6)
			`CHK("itp_end", tgt, pos)
			`CHK("itp_short", v < brake, shrt)
			pin <= 3'h0;
		end
		// below travel command, remaining equal to distance, decelerating
		for (int k = 0; k < 3; k++) begin
			v = 20 + rnd(30);
			// one unit is used up before the step is taken
			load_rem(k == 1 ? v + 1 : 32'd1000);
			tcmd  <= (k == 0) ? v + 1 : v;
			decel <= (k == 2);
			g = gos;
			step(OP_INTERRUPT_POS, v);
			`CHK("skip_lat", 2, n)
			`CHK("skip_go", g, gos)
			decel <= 1'b0;
		end
		print_verdict();
	end
endmodule : dip_sequencer_tb
